// file: core/dcbo_regs.vh
// Purpose: Constants for the data cache block operation unit
// Assumes: 32-bit instruction words, bit 0 is the most significant bit
// Notes: Register offsets are word indices on the plain register port
`ifndef DCBO_REGS_VH
`define DCBO_REGS_VH
`define DCBO_PRIMARY_OP 6'h1f
`define DCBO_XO_FLUSH 10'h056
`define DCBO_XO_INVAL 10'h1d6
`define DCBO_XO_STORE 10'h036
`define DCBO_XO_TOUCH 10'h116
`define DCBO_XO_TOUCHST 10'h0f6
`define DCBO_REG_CFG 2'h0
`define DCBO_REG_STAT 2'h1
`define DCBO_REG_LAST_EA 2'h2
`define DCBO_CFG_UAXE_BIT 0
`define DCBO_CFG_RESET 32'h00000000
`define DCBO_ST_IDLE 3'h0
`define DCBO_ST_LOOKUP 3'h1
`define DCBO_ST_WB 3'h2
`define DCBO_ST_FILL 3'h3
`define DCBO_ST_DONE 3'h4
`endif

// file: core/dcbo_unit.v
// Purpose: Executes the five data cache line instructions (flush, invalidate,
//          store-line, touch, touch-for-store) and decides their exceptions.
// Assumes: Pipeline presents one instruction at a time with operands already read;
//          cache lookup and translation answer combinationally in the lookup cycle.
// Notes: Memory write-back and fill are handshaken with a done pulse from memory.
//        CLK_EN_I low freezes every register, read data included.
//        A debug match suppresses the cache action; touch faults end silently.
`timescale 1ns/10ps
`default_nettype none
`include "dcbo_regs.vh"
module dcbo_unit (
   input wire SYS_CLK_I,
   input wire ARST_N_I,
   input wire CLK_EN_I,
   // Pipeline side
   input wire INSN_VALID_I,
   input wire [31:0] INSN_I,
   input wire [31:0] BASE_VAL_I,
   input wire [31:0] INDEX_VAL_I,
   input wire USER_MODE_I,
   input wire DATA_RELOC_I,
   output wire INSN_READY_O,
   // Cache and translation lookup
   output wire [31:0] LOOKUP_EA_O,
   input wire LINE_HIT_I,
   input wire LINE_MODIFIED_I,
   input wire ATTR_CACHABLE_I,
   input wire ATTR_USER_DEFINED_I,
   input wire TLB_HIT_I,
   input wire ZONE_NO_ACCESS_I,
   input wire ZONE_READ_ONLY_I,
   // Address compare
   input wire DAC_MATCH_I,
   output reg DAC_CHECK_O,
   output reg DAC_IS_STORE_O,
   // Cache line actions
   output reg CACHE_INVAL_O,
   output reg CACHE_CLEAN_O,
   // Main memory
   output reg MEM_WB_REQ_O,
   output reg MEM_FILL_REQ_O,
   output reg [31:0] MEM_ADDR_O,
   input wire MEM_DONE_I,
   // Completion and exceptions
   output reg DONE_O,
   output reg EXC_DSI_O,
   output reg EXC_DTLB_O,
   output reg EXC_PROG_O,
   output reg EXC_DEBUG_O,
   // Register port
   input wire [1:0] REG_ADDR_I,
   input wire [31:0] REG_WDATA_I,
   input wire REG_WR_I,
   input wire REG_RD_I,
   output reg [31:0] REG_RDATA_O
);

   reg [2:0] state_r;
   reg [2:0] state_nxt;
   reg [2:0] op_r;
   reg [31:0] ea_r;
   reg [31:0] cfg_r;
   reg [31:0] last_ea_r;
   reg [7:0] done_cnt_r;
   wire [5:0] primary = INSN_I[31:26];
   wire [4:0] base_field = INSN_I[20:16];
   wire [9:0] xo = INSN_I[10:1];
   // Reserved bits (rD field, bit 31) are deliberately not decoded
   wire is_flush = (primary == `DCBO_PRIMARY_OP) && (xo == `DCBO_XO_FLUSH);
   wire is_inval = (primary == `DCBO_PRIMARY_OP) && (xo == `DCBO_XO_INVAL);
   wire is_store = (primary == `DCBO_PRIMARY_OP) && (xo == `DCBO_XO_STORE);
   wire is_touch = (primary == `DCBO_PRIMARY_OP) &&
      ((xo == `DCBO_XO_TOUCH) || (xo == `DCBO_XO_TOUCHST));
   wire is_ours = is_flush | is_inval | is_store | is_touch;
   wire [31:0] base_val = (base_field == 5'h00) ? 32'h00000000 : BASE_VAL_I;
   wire [31:0] ea = base_val + INDEX_VAL_I;

   localparam OP_FLUSH = 3'h0;
   localparam OP_INVAL = 3'h1;
   localparam OP_STORE = 3'h2;
   localparam OP_TOUCH = 3'h3;
   reg user_r;
   reg reloc_r;
   wire uaxe = cfg_r[`DCBO_CFG_UAXE_BIT];

   // Exception decisions in the lookup cycle
   wire tlb_miss = reloc_r & ~TLB_HIT_I;
   wire na_fault = reloc_r & user_r & ZONE_NO_ACCESS_I;
   wire dsi_fl_st = na_fault;
   wire dsi_inv = na_fault | (reloc_r & ZONE_READ_ONLY_I) |
      (ATTR_USER_DEFINED_I & uaxe);

   reg dsi;
   reg dtlb;
   always @* begin
      dsi = 1'b0;
      dtlb = 1'b0;
      case (op_r)
         OP_FLUSH: begin
            dsi = dsi_fl_st;
            dtlb = tlb_miss;
         end
         OP_STORE: begin
            dsi = dsi_fl_st;
            dtlb = tlb_miss;
         end
         OP_INVAL: begin
            dsi = dsi_inv;
            dtlb = tlb_miss;
         end
         default: begin
            dsi = 1'b0;
            dtlb = 1'b0;
         end
      endcase
   end

   wire excp = dsi | dtlb | DAC_MATCH_I;
   // Touch drops silently on a would-be fault
   wire touch_blocked = tlb_miss | na_fault;
   assign INSN_READY_O = (state_r == `DCBO_ST_IDLE);
   assign LOOKUP_EA_O = ea_r;

   wire take = INSN_VALID_I && is_ours && (state_r == `DCBO_ST_IDLE);
   wire priv_fault = is_inval && USER_MODE_I;
   wire in_lookup = (state_r == `DCBO_ST_LOOKUP);
   reg [2:0] op_dec;
   always @* begin
      if (is_flush) begin
         op_dec = OP_FLUSH;
      end else if (is_inval) begin
         op_dec = OP_INVAL;
      end else if (is_store) begin
         op_dec = OP_STORE;
      end else begin
         op_dec = OP_TOUCH;
      end
   end

   always @* begin
      state_nxt = state_r;
      case (state_r)
         `DCBO_ST_IDLE: begin
            if (INSN_VALID_I && is_ours && !(is_inval && USER_MODE_I)) begin
               state_nxt = `DCBO_ST_LOOKUP;
            end else if (INSN_VALID_I && is_ours) begin
               state_nxt = `DCBO_ST_DONE;
            end
         end
         `DCBO_ST_LOOKUP: begin
            if (excp) begin
               state_nxt = `DCBO_ST_DONE;
            end else if ((op_r == OP_FLUSH || op_r == OP_STORE) &&
               LINE_HIT_I && LINE_MODIFIED_I) begin
               state_nxt = `DCBO_ST_WB;
            end else if (op_r == OP_TOUCH && !touch_blocked && !LINE_HIT_I &&
               ATTR_CACHABLE_I) begin
               state_nxt = `DCBO_ST_FILL;
            end else begin
               state_nxt = `DCBO_ST_DONE;
            end
         end
         `DCBO_ST_WB: begin
            if (MEM_DONE_I) begin
               state_nxt = `DCBO_ST_DONE;
            end
         end
         `DCBO_ST_FILL: begin
            if (MEM_DONE_I) begin
               state_nxt = `DCBO_ST_DONE;
            end
         end
         `DCBO_ST_DONE: begin
            state_nxt = `DCBO_ST_IDLE;
         end
         default: begin
            state_nxt = `DCBO_ST_IDLE;
         end
      endcase
   end
   // Operands are latched once so the lookup sees a stable address
   always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_r <= `DCBO_ST_IDLE;
         op_r <= OP_FLUSH;
         ea_r <= 32'h00000000;
         user_r <= 1'b0;
         reloc_r <= 1'b0;
      end else if (CLK_EN_I) begin
         state_r <= state_nxt;
         if (take) begin
            ea_r <= ea;
            user_r <= USER_MODE_I;
            reloc_r <= DATA_RELOC_I;
            op_r <= op_dec;
         end
      end
   end

   // Read mux; only the registered copy leaves the block
   reg [31:0] rdata_nxt;
   always @* begin
      rdata_nxt = 32'h00000000;
      if (REG_RD_I) begin
         case (REG_ADDR_I)
            `DCBO_REG_CFG: rdata_nxt = cfg_r;
            `DCBO_REG_STAT: rdata_nxt = {21'h0, done_cnt_r, state_r};
            `DCBO_REG_LAST_EA: rdata_nxt = last_ea_r;
            default: rdata_nxt = 32'h00000000;
         endcase
      end
   end

   // Read data stand only in the cycle after the read strobe
   always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         cfg_r <= `DCBO_CFG_RESET;
         REG_RDATA_O <= 32'h00000000;
      end else if (CLK_EN_I) begin
         if (REG_WR_I && REG_ADDR_I == `DCBO_REG_CFG) begin
            cfg_r <= REG_WDATA_I;
         end
         REG_RDATA_O <= rdata_nxt;
      end
   end

   // Status bookkeeping; the count wraps, software only looks at differences
   always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         last_ea_r <= 32'h00000000;
         done_cnt_r <= 8'h00;
      end else if (CLK_EN_I) begin
         if (in_lookup) begin
            last_ea_r <= ea_r;
         end
         if (state_r == `DCBO_ST_DONE) begin
            done_cnt_r <= done_cnt_r + 8'h01;
         end
      end
   end

   // Address compare is asked for in the lookup cycle, on the latched address
   always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         DAC_CHECK_O <= 1'b0;
         DAC_IS_STORE_O <= 1'b0;
         EXC_DEBUG_O <= 1'b0;
      end else if (CLK_EN_I) begin
         DAC_CHECK_O <= take && !priv_fault;
         if (take && !priv_fault) begin
            DAC_IS_STORE_O <= ~is_touch;
         end
         EXC_DEBUG_O <= in_lookup && DAC_MATCH_I;
      end
   end

   always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         EXC_DSI_O <= 1'b0;
         EXC_DTLB_O <= 1'b0;
         EXC_PROG_O <= 1'b0;
      end else if (CLK_EN_I) begin
         EXC_PROG_O <= take && priv_fault;
         EXC_DSI_O <= in_lookup && dsi;
         EXC_DTLB_O <= in_lookup && dtlb;
      end
   end

   // A modified flush line is dropped only once memory has taken the write-back
   always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         CACHE_INVAL_O <= 1'b0;
         CACHE_CLEAN_O <= 1'b0;
      end else if (CLK_EN_I) begin
         CACHE_INVAL_O <= 1'b0;
         CACHE_CLEAN_O <= 1'b0;
         if (in_lookup && !excp && LINE_HIT_I) begin
            if (op_r == OP_INVAL) begin
               CACHE_INVAL_O <= 1'b1;
            end else if (op_r == OP_FLUSH && !LINE_MODIFIED_I) begin
               CACHE_INVAL_O <= 1'b1;
            end
         end
         if (state_r == `DCBO_ST_WB && MEM_DONE_I) begin
            CACHE_INVAL_O <= (op_r == OP_FLUSH);
            CACHE_CLEAN_O <= (op_r == OP_STORE);
         end
      end
   end

   // Requests hold until memory answers with its done pulse
   always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         MEM_WB_REQ_O <= 1'b0;
         MEM_FILL_REQ_O <= 1'b0;
         MEM_ADDR_O <= 32'h00000000;
      end else if (CLK_EN_I) begin
         if (in_lookup) begin
            MEM_ADDR_O <= ea_r;
            MEM_WB_REQ_O <= (state_nxt == `DCBO_ST_WB);
            MEM_FILL_REQ_O <= (state_nxt == `DCBO_ST_FILL);
         end else if (MEM_DONE_I) begin
            MEM_WB_REQ_O <= 1'b0;
            MEM_FILL_REQ_O <= 1'b0;
         end
      end
   end

   always @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         DONE_O <= 1'b0;
      end else if (CLK_EN_I) begin
         DONE_O <= (state_r == `DCBO_ST_DONE);
      end
   end
endmodule
`default_nettype wire

// file: tb/dcbo_asserts.sv
// Purpose: Port-level assertions for the data cache line unit
// Assumes: Lookup answers are held steady while an instruction runs
// Notes: Ports are grouped on a line to keep the file short
`timescale 1ns/10ps
`default_nettype none
`include "dcbo_regs.vh"
module dcbo_asserts (
   input wire logic SYS_CLK_I, ARST_N_I, INSN_VALID_I, INSN_READY_O, USER_MODE_I,
   input wire logic [31:0] INSN_I, BASE_VAL_I, INDEX_VAL_I, LOOKUP_EA_O,
   input wire logic DATA_RELOC_I, LINE_HIT_I, ATTR_CACHABLE_I, TLB_HIT_I, DAC_MATCH_I,
   input wire logic DAC_CHECK_O, DAC_IS_STORE_O, CACHE_INVAL_O, CACHE_CLEAN_O, DONE_O,
   input wire logic MEM_WB_REQ_O, MEM_FILL_REQ_O, MEM_DONE_I, EXC_DSI_O, EXC_DTLB_O, EXC_PROG_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!ARST_N_I);
   wire logic [9:0] xo = INSN_I[10:1];
   wire logic inval = xo == `DCBO_XO_INVAL;
   wire logic touch = xo == `DCBO_XO_TOUCH || xo == `DCBO_XO_TOUCHST;
   wire logic known = inval || touch || xo == `DCBO_XO_FLUSH || xo == `DCBO_XO_STORE;
   wire logic take = INSN_VALID_I && INSN_READY_O && INSN_I[31:26] == `DCBO_PRIMARY_OP && known;
   wire logic [31:0] ea_w = INDEX_VAL_I + (INSN_I[20:16] == 5'h00 ? 32'h0 : BASE_VAL_I);
   sequence take_s;
      take;
   endsequence
   ea_calc_a: assert property (take_s |=> !DAC_CHECK_O || LOOKUP_EA_O == $past(ea_w))
      else $error("lookup address wrong");
   prog_user_a: assert property (take_s ##0 (inval && USER_MODE_I) |=> !DAC_CHECK_O && EXC_PROG_O ##1 DONE_O)
      else $error("user invalidate not refused");
   inval_nowb_a: assert property (take_s ##0 inval |=> !MEM_WB_REQ_O [*8])
      else $error("invalidate wrote back");
   wb_order_a: assert property (MEM_WB_REQ_O && MEM_DONE_I |=> (CACHE_INVAL_O || CACHE_CLEAN_O) && !MEM_WB_REQ_O)
      else $error("line action not after write-back");
   fill_cause_a: assert property ($rose(MEM_FILL_REQ_O) |-> $past(ATTR_CACHABLE_I) && !$past(LINE_HIT_I))
      else $error("fill without cachable miss");
   touch_quiet_a: assert property (DAC_CHECK_O && !DAC_IS_STORE_O |=> !(EXC_DSI_O || EXC_DTLB_O))
      else $error("touch raised access fault");
   tlb_miss_a: assert property (DAC_CHECK_O && DAC_IS_STORE_O && DATA_RELOC_I && !TLB_HIT_I && !DAC_MATCH_I |=> EXC_DTLB_O || EXC_DSI_O)
      else $error("missing translation fault");
   dac_kind_a: assert property (take_s ##0 !(inval && USER_MODE_I) |=> DAC_CHECK_O && DAC_IS_STORE_O == !$past(touch))
      else $error("address compare kind wrong");
   done_bound_a: assert property (take_s |-> ##[2:20] DONE_O)
      else $error("instruction never finished");
endmodule
bind dcbo_unit dcbo_asserts chk_i (.SYS_CLK_I, .ARST_N_I, .INSN_VALID_I, .INSN_READY_O, .USER_MODE_I,
   .INSN_I, .BASE_VAL_I, .INDEX_VAL_I, .LOOKUP_EA_O, .DATA_RELOC_I, .LINE_HIT_I, .ATTR_CACHABLE_I,
   .TLB_HIT_I, .DAC_MATCH_I, .DAC_CHECK_O, .DAC_IS_STORE_O, .CACHE_INVAL_O, .CACHE_CLEAN_O, .DONE_O,
   .MEM_WB_REQ_O, .MEM_FILL_REQ_O, .MEM_DONE_I, .EXC_DSI_O, .EXC_DTLB_O, .EXC_PROG_O);
`default_nettype wire

// file: tb/dcbo_mem_model.sv
// Purpose: Main memory answering line write-backs and fills
// Assumes: Requests stay high until the done pulse is seen
// Notes: Slow mode makes the unit wait several cycles
`timescale 1ns/10ps
`default_nettype none
module dcbo_mem_model (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic wb_req_i,
   input wire logic fill_req_i,
   input wire logic slow_i,
   output logic done_o
);
   logic [2:0] cnt_r;
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r <= 3'h0;
         done_o <= 1'b0;
      end else begin
         done_o <= 1'b0;
         // Request is still seen the edge after done, so restart then
         if (!(wb_req_i || fill_req_i) || done_o) begin
            cnt_r <= 3'h0;
         end else if (cnt_r == (slow_i ? 3'h5 : 3'h0)) begin
            done_o <= 1'b1;
            cnt_r <= 3'h0;
         end else begin
            cnt_r <= cnt_r + 3'h1;
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/data_cache_block_ops_bench.sv
// Purpose: Self-checking bench for the data cache line unit
// Assumes: Each row is {opcode, lookup answers, expected events}
// Notes: Events are gathered over the whole instruction, not per cycle
`timescale 1ns/10ps
`default_nettype none
`include "dcbo_regs.vh"
module data_cache_block_ops_bench;
   logic SYS_CLK_I = 0, ARST_N_I = 0, INSN_VALID_I = 0, USER_MODE_I = 0, DATA_RELOC_I = 0;
   logic LINE_HIT_I = 0, LINE_MODIFIED_I = 0, ATTR_CACHABLE_I = 0, ATTR_USER_DEFINED_I = 0;
   logic TLB_HIT_I = 0, ZONE_NO_ACCESS_I = 0, ZONE_READ_ONLY_I = 0, DAC_MATCH_I = 0, slow = 0;
   logic REG_WR_I = 0, REG_RD_I = 0, done, CLK_EN_I = 1;
   logic [31:0] ma;
   logic [1:0] REG_ADDR_I = 0;
   logic [8:0] seen;
   logic [31:0] INSN_I = 0, BASE_VAL_I = 0, INDEX_VAL_I = 0, REG_WDATA_I = 0, r, ea;
   wire logic INSN_READY_O, DAC_CHECK_O, DAC_IS_STORE_O, CACHE_INVAL_O, CACHE_CLEAN_O, DONE_O;
   wire logic MEM_WB_REQ_O, MEM_FILL_REQ_O, MEM_DONE_I, EXC_DSI_O, EXC_DTLB_O, EXC_PROG_O;
   wire logic EXC_DEBUG_O;
   wire logic [31:0] LOOKUP_EA_O, MEM_ADDR_O, REG_RDATA_O;
   int err_count = 0, num_checks = 0, cyc = 0, i, n;
   // Answers: user reloc hit mod cach uattr tlb noacc ronly dac
   // Events: wb fill inval clean dsi dtlb prog dbg store_compare
   logic [28:0] rows [0:21] = '{
      {`DCBO_XO_FLUSH, 10'b0011101000, 9'b101000001}, {`DCBO_XO_FLUSH, 10'b0010001000, 9'b001000001},
      {`DCBO_XO_FLUSH, 10'b0000111000, 9'b000000001}, {`DCBO_XO_FLUSH, 10'b1110101100, 9'b000010001},
      {`DCBO_XO_FLUSH, 10'b0100101100, 9'b000000001}, {`DCBO_XO_FLUSH, 10'b1110101010, 9'b001000001},
      {`DCBO_XO_STORE, 10'b0011001000, 9'b100100001}, {`DCBO_XO_STORE, 10'b0010101000, 9'b000000001},
      {`DCBO_XO_STORE, 10'b0110100000, 9'b000001001}, {`DCBO_XO_INVAL, 10'b1010101000, 9'b000000100},
      {`DCBO_XO_INVAL, 10'b0011001000, 9'b001000001}, {`DCBO_XO_INVAL, 10'b0110101010, 9'b000010001},
      {`DCBO_XO_INVAL, 10'b0100101100, 9'b000000001}, {`DCBO_XO_INVAL, 10'b0010111000, 9'b000010001},
      {`DCBO_XO_INVAL, 10'b0110100000, 9'b000001001}, {`DCBO_XO_TOUCH, 10'b0000101000, 9'b010000000},
      {`DCBO_XO_TOUCH, 10'b0010101000, 9'b000000000}, {`DCBO_XO_TOUCH, 10'b0000001000, 9'b000000000},
      {`DCBO_XO_TOUCH, 10'b0100100000, 9'b000000000}, {`DCBO_XO_TOUCHST, 10'b0000101000, 9'b010000000},
      {`DCBO_XO_TOUCHST, 10'b1100101100, 9'b000000000}, {`DCBO_XO_FLUSH, 10'b0011101001, 9'b000000011}};
   dcbo_unit dut (.SYS_CLK_I, .ARST_N_I, .CLK_EN_I, .INSN_VALID_I, .INSN_I, .BASE_VAL_I,
      .INDEX_VAL_I, .USER_MODE_I, .DATA_RELOC_I, .INSN_READY_O, .LOOKUP_EA_O, .LINE_HIT_I,
      .LINE_MODIFIED_I, .ATTR_CACHABLE_I, .ATTR_USER_DEFINED_I, .TLB_HIT_I, .ZONE_NO_ACCESS_I,
      .ZONE_READ_ONLY_I, .DAC_MATCH_I, .DAC_CHECK_O, .DAC_IS_STORE_O, .CACHE_INVAL_O, .CACHE_CLEAN_O,
      .MEM_WB_REQ_O, .MEM_FILL_REQ_O, .MEM_ADDR_O, .MEM_DONE_I, .DONE_O, .EXC_DSI_O, .EXC_DTLB_O,
      .EXC_PROG_O, .EXC_DEBUG_O, .REG_ADDR_I, .REG_WDATA_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O);
   dcbo_mem_model mem (.clk_i(SYS_CLK_I), .rst_n_i(ARST_N_I), .wb_req_i(MEM_WB_REQ_O),
      .fill_req_i(MEM_FILL_REQ_O), .slow_i(slow), .done_o(MEM_DONE_I));
   always #10 SYS_CLK_I = ~SYS_CLK_I;
   task results;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge SYS_CLK_I) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         results;
      end
   end
   task chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   task wr(input logic [1:0] a, input logic [31:0] d);
      @(posedge SYS_CLK_I);
      REG_ADDR_I <= a;
      REG_WDATA_I <= d;
      REG_WR_I <= 1;
      @(posedge SYS_CLK_I);
      REG_WR_I <= 0;
   endtask
   task rd(input logic [1:0] a);
      @(posedge SYS_CLK_I);
      REG_ADDR_I <= a;
      REG_RD_I <= 1;
      @(posedge SYS_CLK_I);
      REG_RD_I <= 0;
      #1 r = REG_RDATA_O;
   endtask
   task run(input logic [9:0] xo, input logic [9:0] in, input logic [5:0] rsv,
         input logic [4:0] ra, input logic [31:0] b, input logic [31:0] x);
      @(posedge SYS_CLK_I);
      INSN_VALID_I <= 1;
      INSN_I <= {`DCBO_PRIMARY_OP, rsv[5:1], ra, 5'h03, xo, rsv[0]};
      {USER_MODE_I, DATA_RELOC_I, LINE_HIT_I, LINE_MODIFIED_I, ATTR_CACHABLE_I,
         ATTR_USER_DEFINED_I, TLB_HIT_I, ZONE_NO_ACCESS_I, ZONE_READ_ONLY_I, DAC_MATCH_I} <= in;
      BASE_VAL_I <= b;
      INDEX_VAL_I <= x;
      seen = 0;
      done = 0;
      ea = '1;
      ma = 0;
      @(posedge SYS_CLK_I);
      INSN_VALID_I <= 0;
      for (n = 0; n < 40 && !done; n++) begin
         #1;
         seen = seen | {MEM_WB_REQ_O, MEM_FILL_REQ_O, CACHE_INVAL_O, CACHE_CLEAN_O, EXC_DSI_O,
            EXC_DTLB_O, EXC_PROG_O, EXC_DEBUG_O, DAC_CHECK_O & DAC_IS_STORE_O};
         if (DAC_CHECK_O === 1'b1) ea = LOOKUP_EA_O;
         if (MEM_WB_REQ_O === 1'b1 || MEM_FILL_REQ_O === 1'b1) ma = MEM_ADDR_O;
         done = (DONE_O === 1'b1);
         @(posedge SYS_CLK_I);
      end
   endtask
   initial begin
      @(posedge SYS_CLK_I);
      #1 chk(INSN_READY_O, 32'h1);
      @(posedge SYS_CLK_I);
      ARST_N_I <= 1;
      wr(2'h0, 32'h1);
      for (i = 0; i < 22; i++) begin
         slow <= i[0];
         run(rows[i][28:19], rows[i][18:9], 6'h00, i[0] ? 5'h05 : 5'h00, 32'h10000000 + i, 32'h40 * i);
         chk({seen, done}, {rows[i][8:0], 1'b1});
         if (i != 9) chk(ea, 32'h40 * i + (i[0] ? 32'h10000000 + i : 32'h0));
         if (rows[i][8] || rows[i][7]) chk(ma, 32'h40 * i + (i[0] ? 32'h10000000 + i : 32'h0));
         $display("test %0d done", i);
      end
      // Reserved fields set on a plain flush miss
      run(`DCBO_XO_FLUSH, 10'b0000101000, 6'h3f, 5'h00, 32'h0, 32'h80);
      chk({seen, done}, 32'h3);
      rd(2'h0);
      chk(r, 32'h1);
      rd(2'h2);
      chk(r, 32'h80);
      rd(2'h3);
      chk(r, 32'h0);
      // A write with the clock enable low must not land
      @(posedge SYS_CLK_I);
      CLK_EN_I <= 0;
      wr(2'h0, 32'h0);
      CLK_EN_I <= 1;
      rd(2'h0);
      chk(r, 32'h1);
      wr(2'h0, 32'h0);
      run(`DCBO_XO_INVAL, 10'b0010111000, 6'h00, 5'h00, 32'h0, 32'h80);
      chk({seen, done}, 32'h83);
      $display("test hand cases done");
      results;
   end
endmodule
`default_nettype wire
